// *** pic_defines.vh ***
// register indices, field positions, reset values and tables of the interrupt controller
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH

// register indices; byte address is four times the index
`define PIC_IDX_TIMER_CTL   8'h88
`define PIC_IDX_SERIAL_CTL  8'h98
`define PIC_IDX_IRQ_EN2     8'h9A
`define PIC_IDX_IRQ_EN1     8'hA8
`define PIC_IDX_PRIO_LOW    8'hA9
`define PIC_IDX_PRIO_HIGH   8'hB9
`define PIC_IDX_IRQ_REQ2    8'hBF
`define PIC_IDX_TWOWIRE_CTL 8'hDC

`define PIC_RST_BYTE        8'h00
`define PIC_RST_PRIO        6'h00

// field positions
`define PIC_EN1_GLOBAL      7
`define PIC_EN1_TWOWIRE     6
`define PIC_EN1_UART_RX     5
`define PIC_EN1_UART_TX     4
`define PIC_EN1_TIMER1      3
`define PIC_EN1_EXT1        2
`define PIC_EN1_TIMER0      1
`define PIC_EN1_EXT0        0
`define PIC_EN2_PWM         3
`define PIC_EN2_EXT2        2
`define PIC_EN2_CONV        0
`define PIC_TCF_TIMER1      7
`define PIC_TCF_TIMER0      5
`define PIC_TCF_EXT1        3
`define PIC_TCF_EXT0        1
`define PIC_REQ2_PWM        3
`define PIC_REQ2_EXT2       2
`define PIC_REQ2_CONV       0
`define PIC_SPC_UART_TX     1
`define PIC_SPC_UART_RX     0
`define PIC_TWC_FLAG        3

// sources in default order: ext0 ext1 ext2 pwm utx tw urx conv t1 t0
`define PIC_NSRC            10
`define PIC_NGRP            6
`define PIC_SRC_GROUPS      {3'h4, 3'h4, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0}
`define PIC_AUTO_CLR_MASK   10'h38F
`define PIC_TW_NO_INFO      8'hF8

`define PIC_VEC_EXT0        16'h0003
`define PIC_VEC_EXT1        16'h0083
`define PIC_VEC_EXT2        16'h0043
`define PIC_VEC_PWM         16'h000B
`define PIC_VEC_UART_TX     16'h0013
`define PIC_VEC_TWOWIRE     16'h0093
`define PIC_VEC_UART_RX     16'h0053
`define PIC_VEC_CONV        16'h001B
`define PIC_VEC_TIMER1      16'h00A3
`define PIC_VEC_TIMER0      16'h0063

`endif

// *** pic_ahb_if.v ***
// AHB-Lite slave front end for the interrupt controller registers
`timescale 1ns/10ps
module pic_ahb_if (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        clkEn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire [7:0]  rdByte,
  output wire [7:0]  regIdx,
  output wire        wrStb,
  output wire [7:0]  wrByte
);

  reg       wrPhReg;
  reg       rdPhReg;
  reg       rdWaitReg;
  reg [7:0] idxReg;
  reg [7:0] rdataReg;

  wire take    = hsel & htrans[1] & hready;
  // out-of-range or misaligned addresses fold to index 0, which maps nothing
  wire inRange = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0) & (hsize == 3'h2);

  // reads take one wait state so a write just before is always seen
  assign hreadyout = ~(rdPhReg & ~rdWaitReg);
  assign hresp     = 1'b0;
  assign hrdata    = {24'h000000, rdataReg};
  assign regIdx    = idxReg;
  assign wrStb     = wrPhReg;
  assign wrByte    = hwdata[7:0];

  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPhReg   <= 1'b0;
      rdPhReg   <= 1'b0;
      rdWaitReg <= 1'b0;
      idxReg    <= 8'h00;
      rdataReg  <= 8'h00;
    end
    else if (clkEn)
    begin
      if (take)
      begin
        wrPhReg   <= hwrite;
        rdPhReg   <= ~hwrite;
        rdWaitReg <= 1'b0;
        idxReg    <= inRange ? haddr[9:2] : 8'h00;
      end
      else if (hreadyout)
      begin
        wrPhReg   <= 1'b0;
        rdPhReg   <= 1'b0;
        rdWaitReg <= 1'b0;
      end
      else
      begin
        rdWaitReg <= 1'b1;
        rdataReg  <= rdByte;
      end
    end
  end

endmodule

// *** pic_arbiter.v ***
// level and default-order arbitration among pending interrupt sources
`timescale 1ns/10ps
`include "pic_defines.vh"
module pic_arbiter (
  input  wire [9:0] req,
  input  wire [5:0] prioHigh,
  input  wire [5:0] prioLow,
  input  wire       curValid,
  input  wire [1:0] curLevel,
  output reg        found,
  output reg  [3:0] winIdx,
  output reg  [1:0] winLvl
);

  localparam [29:0] SRC_GROUPS = `PIC_SRC_GROUPS;

  wire [19:0] srcLvl;
  integer     i;

  genvar g;
  generate
    for (g = 0; g < `PIC_NSRC; g = g + 1)
    begin : gLvl
      wire [2:0] grp = SRC_GROUPS[3*g+2:3*g];
      assign srcLvl[2*g+1:2*g] = {prioHigh[grp], prioLow[grp]};
    end
  endgenerate

  // walk from lowest default priority up so ties settle on the lower index
  always @*
  begin
    found  = 1'b0;
    winIdx = 4'h0;
    winLvl = 2'h0;
    for (i = `PIC_NSRC - 1; i >= 0; i = i - 1)
    begin
      if (req[i] && (!curValid || srcLvl[2*i +: 2] > curLevel) &&
          (!found || srcLvl[2*i +: 2] >= winLvl))
      begin
        found  = 1'b1;
        winIdx = i[3:0];
        winLvl = srcLvl[2*i +: 2];
      end
    end
  end

endmodule

// *** pic_ctrl.v ***
// top of the prioritized interrupt controller: flags, enables, nesting and vector output
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "pic_defines.vh"

module pic_ctrl (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        clkEn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire        ext0Event,
  input  wire        ext1Event,
  input  wire        ext2Event,
  input  wire        pwmEvent,
  input  wire        uartTxEvent,
  input  wire        uartRxEvent,
  input  wire        twStateEnter,
  input  wire [7:0]  twStateCode,
  input  wire        convEvent,
  input  wire        timer1Event,
  input  wire        timer0Event,
  output wire        irqReq,
  output wire [15:0] irqVector,
  input  wire        irqAck,
  input  wire        isrReturn,
  output wire [3:0]  activeLevels
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [9:0]  flagReg;
  reg  [9:0]  flagNext;
  reg  [7:0]  en1Reg;
  reg  [2:0]  en2Reg;
  reg  [5:0]  prioLowReg;
  reg  [5:0]  prioHighReg;
  reg  [3:0]  actReg;
  reg  [3:0]  actNext;
  reg         validReg;
  reg  [3:0]  srcReg;
  reg  [1:0]  lvlReg;
  reg  [15:0] vecReg;
  reg  [7:0]  rdByte;
  reg         curValid;
  reg  [1:0]  curLevel;

  wire [7:0]  regIdx;
  wire        wrStb;
  wire [7:0]  wrByte;
  wire        found;
  wire [3:0]  winIdx;
  wire [1:0]  winLvl;
  wire [9:0]  hwSet;
  wire [9:0]  srcEn;
  wire [9:0]  swHit;
  wire [9:0]  swBit;
  wire [9:0]  eligible;
  wire        accept;

  assign irqReq       = validReg;
  assign irqVector    = vecReg;
  assign activeLevels = actReg;
  // an ack only counts while a vector is shown; a stray ack is dropped
  assign accept       = irqAck & validReg;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  pic_ahb_if uBus (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .clkEn     (clkEn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rdByte    (rdByte),
    .regIdx    (regIdx),
    .wrStb     (wrStb),
    .wrByte    (wrByte)
  );

  wire wrTimerCtl = wrStb & (regIdx == `PIC_IDX_TIMER_CTL);
  wire wrSerial   = wrStb & (regIdx == `PIC_IDX_SERIAL_CTL);
  wire wrReq2     = wrStb & (regIdx == `PIC_IDX_IRQ_REQ2);
  wire wrTwoWire  = wrStb & (regIdx == `PIC_IDX_TWOWIRE_CTL);

  // ----------------------------------------------------------------
  // per-source event, enable and software write mapping
  // ----------------------------------------------------------------
  assign hwSet[0] = ext0Event;
  assign hwSet[1] = ext1Event;
  assign hwSet[2] = ext2Event;
  assign hwSet[3] = pwmEvent;
  assign hwSet[4] = uartTxEvent;
  assign hwSet[5] = twStateEnter & (twStateCode != `PIC_TW_NO_INFO);
  assign hwSet[6] = uartRxEvent;
  assign hwSet[7] = convEvent;
  assign hwSet[8] = timer1Event;
  assign hwSet[9] = timer0Event;

  assign srcEn[0] = en1Reg[`PIC_EN1_EXT0];
  assign srcEn[1] = en1Reg[`PIC_EN1_EXT1];
  assign srcEn[2] = en2Reg[1];
  assign srcEn[3] = en2Reg[2];
  assign srcEn[4] = en1Reg[`PIC_EN1_UART_TX];
  assign srcEn[5] = en1Reg[`PIC_EN1_TWOWIRE];
  assign srcEn[6] = en1Reg[`PIC_EN1_UART_RX];
  assign srcEn[7] = en2Reg[0];
  assign srcEn[8] = en1Reg[`PIC_EN1_TIMER1];
  assign srcEn[9] = en1Reg[`PIC_EN1_TIMER0];

  assign swHit[0] = wrTimerCtl;
  assign swBit[0] = wrByte[`PIC_TCF_EXT0];
  assign swHit[1] = wrTimerCtl;
  assign swBit[1] = wrByte[`PIC_TCF_EXT1];
  assign swHit[2] = wrReq2;
  assign swBit[2] = wrByte[`PIC_REQ2_EXT2];
  assign swHit[3] = wrReq2;
  assign swBit[3] = wrByte[`PIC_REQ2_PWM];
  assign swHit[4] = wrSerial;
  assign swBit[4] = wrByte[`PIC_SPC_UART_TX];
  // a one written to the two-wire flag is not a write at all
  assign swHit[5] = wrTwoWire & ~wrByte[`PIC_TWC_FLAG];
  assign swBit[5] = 1'b0;
  assign swHit[6] = wrSerial;
  assign swBit[6] = wrByte[`PIC_SPC_UART_RX];
  assign swHit[7] = wrReq2;
  assign swBit[7] = wrByte[`PIC_REQ2_CONV];
  assign swHit[8] = wrTimerCtl;
  assign swBit[8] = wrByte[`PIC_TCF_TIMER1];
  assign swHit[9] = wrTimerCtl;
  assign swBit[9] = wrByte[`PIC_TCF_TIMER0];

  assign eligible = flagReg & srcEn & {10{en1Reg[`PIC_EN1_GLOBAL]}};

  // ----------------------------------------------------------------
  // request flags
  // ----------------------------------------------------------------
  localparam [9:0] AUTO_CLR = `PIC_AUTO_CLR_MASK;
  // uart and two-wire flags are left out of the mask: software owns them

  genvar s;
  generate
    for (s = 0; s < `PIC_NSRC; s = s + 1)
    begin : gFlag
      // hardware set beats any clear in the same cycle
      always @*
      begin
        if (hwSet[s])
          flagNext[s] = 1'b1;
        else if (accept && srcReg == s && AUTO_CLR[s])
          flagNext[s] = 1'b0;
        else if (swHit[s])
          flagNext[s] = swBit[s];
        else
          flagNext[s] = flagReg[s];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // nesting: one active bit per level
  // ----------------------------------------------------------------
  always @*
  begin
    curValid = |actReg;
    if (actReg[3])
      curLevel = 2'h3;
    else if (actReg[2])
      curLevel = 2'h2;
    else if (actReg[1])
      curLevel = 2'h1;
    else
      curLevel = 2'h0;
  end

  // return pops before accept pushes, so both in one cycle nest correctly
  always @*
  begin
    actNext = actReg;
    if (isrReturn && curValid)
      actNext[curLevel] = 1'b0;
    if (accept)
      actNext[lvlReg] = 1'b1;
  end

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  // the pick is pure logic and is registered below: one cycle of latency
  // traded for a vector that never glitches towards the core
  pic_arbiter uArb (
    .req      (eligible),
    .prioHigh (prioHighReg),
    .prioLow  (prioLowReg),
    .curValid (curValid),
    .curLevel (curLevel),
    .found    (found),
    .winIdx   (winIdx),
    .winLvl   (winLvl)
  );

  function [15:0] vecOf;
    input [3:0] idx;
    begin
      case (idx)
        4'h0:    vecOf = `PIC_VEC_EXT0;
        4'h1:    vecOf = `PIC_VEC_EXT1;
        4'h2:    vecOf = `PIC_VEC_EXT2;
        4'h3:    vecOf = `PIC_VEC_PWM;
        4'h4:    vecOf = `PIC_VEC_UART_TX;
        4'h5:    vecOf = `PIC_VEC_TWOWIRE;
        4'h6:    vecOf = `PIC_VEC_UART_RX;
        4'h7:    vecOf = `PIC_VEC_CONV;
        4'h8:    vecOf = `PIC_VEC_TIMER1;
        default: vecOf = `PIC_VEC_TIMER0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unused and reserved bits read as zero
  always @*
  begin
    if (regIdx == `PIC_IDX_TIMER_CTL)
      rdByte = {flagReg[8], 1'b0, flagReg[9], 1'b0, flagReg[1], 1'b0, flagReg[0], 1'b0};
    else if (regIdx == `PIC_IDX_SERIAL_CTL)
      rdByte = {6'h00, flagReg[4], flagReg[6]};
    else if (regIdx == `PIC_IDX_IRQ_EN2)
      rdByte = {4'h0, en2Reg[2], en2Reg[1], 1'b0, en2Reg[0]};
    else if (regIdx == `PIC_IDX_IRQ_EN1)
      rdByte = en1Reg;
    else if (regIdx == `PIC_IDX_PRIO_LOW)
      rdByte = {2'h0, prioLowReg};
    else if (regIdx == `PIC_IDX_PRIO_HIGH)
      rdByte = {2'h0, prioHighReg};
    else if (regIdx == `PIC_IDX_IRQ_REQ2)
      rdByte = {4'h0, flagReg[3], flagReg[2], 1'b0, flagReg[7]};
    else if (regIdx == `PIC_IDX_TWOWIRE_CTL)
      rdByte = {4'h0, flagReg[5], 3'h0};
    else
      rdByte = 8'h00;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      flagReg     <= 10'h000;
      en1Reg      <= `PIC_RST_BYTE;
      en2Reg      <= 3'h0;
      prioLowReg  <= `PIC_RST_PRIO;
      prioHighReg <= `PIC_RST_PRIO;
      actReg      <= 4'h0;
    end
    else if (clkEn)
    begin
      // flags and levels move only while the clock enable is high
      flagReg <= flagNext;
      actReg  <= actNext;
      if (wrStb && regIdx == `PIC_IDX_IRQ_EN1)
        en1Reg <= wrByte;
      if (wrStb && regIdx == `PIC_IDX_IRQ_EN2)
        en2Reg <= {wrByte[`PIC_EN2_PWM], wrByte[`PIC_EN2_EXT2], wrByte[`PIC_EN2_CONV]};
      if (wrStb && regIdx == `PIC_IDX_PRIO_LOW)
        prioLowReg <= wrByte[5:0];
      if (wrStb && regIdx == `PIC_IDX_PRIO_HIGH)
        prioHighReg <= wrByte[5:0];
    end
  end

  // ----------------------------------------------------------------
  // vector presentation
  // ----------------------------------------------------------------
  // after accept or return the request drops for one cycle so the
  // winner is chosen again from the updated flags and levels
  always @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      validReg <= 1'b0;
      srcReg   <= 4'h0;
      lvlReg   <= 2'h0;
      vecReg   <= 16'h0000;
    end
    else if (clkEn)
    begin
      if (accept || isrReturn)
        validReg <= 1'b0;
      else
      begin
        validReg <= found;
        srcReg   <= winIdx;
        lvlReg   <= winLvl;
        vecReg   <= vecOf(winIdx);
      end
    end
  end

endmodule

// *** pic_ctrl_monitor.sv ***
// assertion checker for the prioritized interrupt controller top
`timescale 1ns/10ps
module pic_ctrl_monitor (
  input wire        clk_sys,
  input wire        nrst,
  input wire        clkEn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire        irqReq,
  input wire [15:0] irqVector,
  input wire        irqAck,
  input wire        isrReturn,
  input wire [3:0]  activeLevels
);
  // ----
  // mirror of the global enable bit
  // ----
  wire taken = hsel && htrans[1] && hready && clkEn;
  reg  enWrPend_reg;
  reg  globalEn_reg;
  always @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      enWrPend_reg <= 1'b0;
      globalEn_reg <= 1'b0;
    end
    else if (clkEn)
    begin
      enWrPend_reg <= taken && hwrite && hsize == 3'h2 && haddr == 32'h2A0;
      if (enWrPend_reg)
        globalEn_reg <= hwdata[7];
    end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_rd_taken; taken && !hwrite; endsequence
  sequence s_one_wait; !hreadyout ##1 hreadyout; endsequence
  sequence s_accept; irqReq && irqAck && clkEn && !isrReturn; endsequence
  sequence s_return; isrReturn && clkEn && !(irqReq && irqAck) && activeLevels != 4'h0; endsequence
  a_read_one_wait: assert property (s_rd_taken |=> s_one_wait)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (taken && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_vector_legal: assert property (irqReq |-> irqVector inside {16'h0003, 16'h0083, 16'h0043, 16'h000B,
    16'h0013, 16'h0093, 16'h0053, 16'h001B, 16'h00A3, 16'h0063})
    else $error("illegal vector");
  a_accept_drops: assert property (s_accept |=> !irqReq)
    else $error("request stayed after accept");
  a_nest_up: assert property (s_accept |=> $countones(activeLevels ^ $past(activeLevels)) == 1 &&
    (activeLevels ^ $past(activeLevels)) > $past(activeLevels))
    else $error("accept not above active levels");
  a_return_pops: assert property (s_return |=> $countones(activeLevels ^ $past(activeLevels)) == 1 &&
    (activeLevels ^ $past(activeLevels)) > activeLevels)
    else $error("return did not clear top level");
  a_return_drops: assert property (isrReturn && clkEn |=> !irqReq)
    else $error("request stayed after return");
  a_levels_hold: assert property (!(irqReq && irqAck) && !isrReturn |=> $stable(activeLevels))
    else $error("active levels changed alone");
  a_global_gate: assert property ($rose(irqReq) |-> $past(globalEn_reg))
    else $error("request with global enable off");
endmodule

bind pic_ctrl pic_ctrl_monitor i_mon (.*);

// *** pic_core_model.sv ***
// behavioural model of the core that accepts vectors and returns
`timescale 1ns/10ps
module pic_core_model (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        irqReq,
  input  wire [15:0] irqVector,
  input  wire        ackEn,
  input  wire [3:0]  ackDelay,
  input  wire        retCmd,
  output reg         irqAck,
  output reg         isrReturn,
  output reg  [15:0] ackVec,
  output reg  [7:0]  ackCount
);
  reg [3:0] waitCnt_reg;
  always @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      irqAck      <= 1'b0;
      isrReturn   <= 1'b0;
      ackVec      <= 16'h0000;
      ackCount    <= 8'h00;
      waitCnt_reg <= 4'h0;
    end
    else
    begin
      irqAck    <= 1'b0;
      // return only on command: routine ends with the return instruction
      isrReturn <= retCmd;
      if (irqAck && irqReq)
      begin
        ackVec      <= irqVector;
        ackCount    <= ackCount + 8'h01;
        waitCnt_reg <= 4'h0;
      end
      else if (irqReq && ackEn && !irqAck)
      begin
        // slow core: vector may change while we dither
        if (waitCnt_reg >= ackDelay)
          irqAck <= 1'b1;
        waitCnt_reg <= waitCnt_reg + 4'h1;
      end
      else
        waitCnt_reg <= 4'h0;
    end
endmodule

// *** pic_ctrl_tb.sv ***
// self-checking testbench of the prioritized interrupt controller
`timescale 1ns/10ps
module pic_ctrl_tb;
  reg clk_sys, nrst, clkEn, hsel, hwrite, ackEn, retCmd;
  reg [31:0] haddr, hwdata;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [9:0] evt;
  reg [7:0] twCode, rdv;
  reg [3:0] ackDelay;
  wire hreadyout, hresp, irqReq, irqAck, isrReturn;
  wire [31:0] hrdata;
  wire [15:0] irqVector, ackVec;
  wire [7:0] ackCount;
  wire [3:0] activeLevels;
  integer mismatches, n_tests, cyc, nAck;
  localparam [111:0] ORDER = {16'h0003, 16'h0083, 16'h0043, 16'h000B, 16'h001B, 16'h00A3, 16'h0063};
  pic_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext0Event(evt[0]), .ext1Event(evt[1]), .ext2Event(evt[2]), .pwmEvent(evt[3]),
    .uartTxEvent(evt[4]), .twStateEnter(evt[5]), .twStateCode(twCode), .uartRxEvent(evt[6]), .convEvent(evt[7]),
    .timer1Event(evt[8]), .timer0Event(evt[9]), .irqReq(irqReq), .irqVector(irqVector), .irqAck(irqAck),
    .isrReturn(isrReturn), .activeLevels(activeLevels));
  pic_core_model i_core (.clk_sys(clk_sys), .nrst(nrst), .irqReq(irqReq), .irqVector(irqVector), .ackEn(ackEn),
    .ackDelay(ackDelay), .retCmd(retCmd), .irqAck(irqAck), .isrReturn(isrReturn), .ackVec(ackVec),
    .ackCount(ackCount));
  // ----
  // shared tasks
  // ----
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  task waitRdy;
    begin
      @(posedge clk_sys);
      while (hreadyout !== 1'b1)
        @(posedge clk_sys);
    end
  endtask
  task xfer(input w, input [31:0] a, input [7:0] d);
    begin
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= a;
      waitRdy;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      waitRdy;
      rdv = hrdata[7:0];
    end
  endtask
  task pulse(input [9:0] m, input [7:0] code);
    begin
      @(posedge clk_sys);
      evt <= m;
      twCode <= code;
      @(posedge clk_sys);
      evt <= 10'h000;
    end
  endtask
  task waitAck(input [15:0] v, input [3:0] lv);
    begin
      while (ackCount === nAck[7:0])
      begin
        @(posedge clk_sys);
        #1;
      end
      nAck = nAck + 1;
      chk("vector", ackVec, v);
      chk("levels", activeLevels, lv);
    end
  endtask
  task ret(input chkIt, input [3:0] lv);
    begin
      @(posedge clk_sys);
      retCmd <= 1'b1;
      @(posedge clk_sys);
      retCmd <= 1'b0;
      repeat (3) @(posedge clk_sys);
      #1;
      if (chkIt)
        chk("levelsRet", activeLevels, lv);
    end
  endtask
  function [39:0] regTab(input integer i);
    case (i)
      0: regTab = {32'h220, 8'hAA};
      1: regTab = {32'h260, 8'h03};
      2: regTab = {32'h268, 8'h0D};
      3: regTab = {32'h2A0, 8'hFF};
      4: regTab = {32'h2A4, 8'h3F};
      5: regTab = {32'h2E4, 8'h3F};
      6: regTab = {32'h2FC, 8'h0D};
      default: regTab = {32'h370, 8'h00};
    endcase
  endfunction
  // ----
  // scenarios
  // ----
  task t_regs;
    integer i;
    reg [39:0] e;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        e = regTab(i);
        xfer(1'b0, e[39:8], 8'h00);
        chk("resetVal", rdv, 8'h00);
        xfer(1'b1, e[39:8], 8'hFF);
        xfer(1'b0, e[39:8], 8'h00);
        chk("writable", rdv, e[7:0]);
        xfer(1'b1, e[39:8], 8'h00);
      end
      xfer(1'b1, 32'h3FC, 8'hFF);
      xfer(1'b0, 32'h3FC, 8'h00);
      chk("unmapped", rdv, 8'h00);
    end
  endtask
  task t_flags;
    begin
      xfer(1'b1, 32'h2A0, 8'h7F);
      xfer(1'b1, 32'h268, 8'h0D);
      pulse(10'h3FF, 8'h10);
      xfer(1'b0, 32'h220, 8'h00);
      chk("timerFlags", rdv, 8'hAA);
      xfer(1'b0, 32'h260, 8'h00);
      chk("uartFlags", rdv, 8'h03);
      xfer(1'b0, 32'h2FC, 8'h00);
      chk("req2Flags", rdv, 8'h0D);
      xfer(1'b0, 32'h370, 8'h00);
      chk("twFlag", rdv, 8'h08);
      chk("noGlobal", irqReq, 1'b0);
      xfer(1'b1, 32'h220, 8'h00);
      xfer(1'b1, 32'h260, 8'h00);
      xfer(1'b1, 32'h2FC, 8'h00);
      xfer(1'b1, 32'h370, 8'h00);
      xfer(1'b0, 32'h370, 8'h00);
      chk("twClear", rdv, 8'h00);
      pulse(10'h020, 8'hF8);
      xfer(1'b0, 32'h370, 8'h00);
      chk("twNoInfo", rdv, 8'h00);
    end
  endtask
  task t_order;
    integer i;
    begin
      xfer(1'b1, 32'h2A0, 8'hFF);
      ackDelay <= 4'h5;
      ackEn <= 1'b1;
      pulse(10'h38F, 8'h10);
      for (i = 0; i < 7; i = i + 1)
      begin
        waitAck(ORDER[111 - 16 * i -: 16], 4'b0001);
        ret(1'b0, 4'h0);
      end
      xfer(1'b0, 32'h220, 8'h00);
      chk("autoClrTcf", rdv, 8'h00);
      xfer(1'b0, 32'h2FC, 8'h00);
      chk("autoClrReq2", rdv, 8'h00);
    end
  endtask
  task t_soft;
    integer i;
    begin
      for (i = 0; i < 3; i = i + 1)
      begin
        pulse(10'h010 << i, 8'h10);
        waitAck(i == 0 ? 16'h0013 : i == 1 ? 16'h0093 : 16'h0053, 4'b0001);
        xfer(1'b0, i == 1 ? 32'h370 : 32'h260, 8'h00);
        chk("softFlag", rdv, i == 0 ? 8'h02 : i == 1 ? 8'h08 : 8'h01);
        xfer(1'b1, i == 1 ? 32'h370 : 32'h260, 8'h00);
        ret(1'b1, 4'h0);
      end
    end
  endtask
  task t_prio;
    begin
      xfer(1'b1, 32'h2E4, 8'h12);
      xfer(1'b1, 32'h2A4, 8'h10);
      ackDelay <= 4'h0;
      pulse(10'h208, 8'h10);
      waitAck(16'h0063, 4'b1000);
      ret(1'b0, 4'h0);
      waitAck(16'h000B, 4'b0100);
      ret(1'b1, 4'h0);
      pulse(10'h001, 8'h10);
      waitAck(16'h0003, 4'b0001);
      pulse(10'h002, 8'h10);
      repeat (10) @(posedge clk_sys);
      chk("noPreempt", ackCount, nAck[7:0]);
      pulse(10'h008, 8'h10);
      waitAck(16'h000B, 4'b0101);
      pulse(10'h200, 8'h10);
      waitAck(16'h0063, 4'b1101);
      ret(1'b1, 4'b0101);
      ret(1'b1, 4'b0001);
      ret(1'b0, 4'h0);
      waitAck(16'h0083, 4'b0001);
      ret(1'b1, 4'h0);
    end
  endtask
  task t_freeze;
    begin
      @(posedge clk_sys);
      clkEn <= 1'b0;
      pulse(10'h001, 8'h10);
      repeat (4) @(posedge clk_sys);
      chk("frozenAck", ackCount, nAck[7:0]);
      chk("frozenReq", irqReq, 1'b0);
      clkEn <= 1'b1;
      xfer(1'b0, 32'h220, 8'h00);
      chk("frozenFlag", rdv, 8'h00);
    end
  endtask
  // ----
  // clock, timeout and main sequence
  // ----
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      results;
    end
  end
  initial
  begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    clkEn = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    evt = 10'h000;
    twCode = 8'h00;
    ackEn = 1'b0;
    ackDelay = 4'h0;
    retCmd = 1'b0;
    mismatches = 0;
    n_tests = 0;
    cyc = 0;
    nAck = 0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs;
    t_flags;
    t_order;
    t_soft;
    t_prio;
    t_freeze;
    results;
  end
endmodule
